// [design/boot_loader.sv]
// Summary of operation
// RL1: Pins 00: skip loading, run from external bank 0 at 0x2000_0000.
// RL2: Pins 01: take the boot stream from parallel PROM or flash.
// RL3: Pins 10: act as SPI slave; the external host supplies the stream.
// RL4: Pins 11: read the boot stream from addressable SPI memory.
// RL5: Leave reset service, enter supervisor at lowest level before any check.
// RL6: Reset config bit 4 set skips the boot and jumps to L1 start.
// RL7: L1 start is a variant parameter, used by loading modes and bypass.
// RL8: Stream is a run of blocks, each opened by a 10-byte header.
// RL9: Header order: 4-byte address, 4-byte count, 2-byte flag word.
// RL10: Count bytes are placed in memory starting at the header address.
// RL11: Nonzero block has a body; zero block is followed by next header.
// RL12: Stream starts with the first block header, no global header.
// RL13: Address and count are taken afresh for every block.
// RL14: Zero-fill block writes count zero bytes and reads no body.
// RL15: Ignore block is not stored; loading moves to the next block.
// RL16: Init block is loaded, called as a routine, then loading resumes.
// RL17: After the last block jump to L1 start, still supervisor, lowest level.
// RL18: Header fields arrive low byte first; flag positions are constants.
// RL19: Bytes are taken only as the source delivers them, stalling in place.
`timescale 1ns/100ps
module boot_loader
  import boot_loader_pkg::*;
#(
  parameter bit l1_variant_b = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Straps and configuration
  input wire logic [1:0] boot_source_select_pins,
  input wire logic [RESET_CFG_W-1:0] reset_config_register,
  // Boot byte source
  input wire logic [7:0] src_data,
  input wire logic src_valid,
  output logic src_ready,
  output logic src_enable,
  output logic [1:0] src_sel,
  // Memory write port
  output logic [31:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  input wire logic mem_ready,
  // Initialization call
  output logic [31:0] call_addr,
  output logic call_req,
  input wire logic call_done,
  // Execution hand-off
  output logic [31:0] exec_addr,
  output logic exec_start,
  output logic reset_service,
  output logic supervisor_mode,
  output logic lowest_priority_level,
  // Status
  output logic loader_busy,
  output logic boot_done,
  output logic [15:0] blocks_loaded
);
  typedef enum logic [3:0] {
    st_reset_svc,
    st_level,
    st_check,
    st_hdr_go,
    st_header,
    st_decide,
    st_copy,
    st_fill,
    st_skip,
    st_after,
    st_call,
    st_post,
    st_jump,
    st_done
  } loader_state_t;

  localparam logic [31:0] L1_START = l1_variant_b ? L1_START_B : L1_START_A; // RL7

  loader_state_t state;
  loader_state_t next_state;
  logic [1:0] pins_meta;
  logic [1:0] pins_sync;
  logic [1:0] mode;
  logic [31:0] dest;
  logic [31:0] remaining;
  logic hdr_busy;
  logic hdr_done;
  logic [31:0] hdr_addr;
  logic [31:0] hdr_count;
  logic [15:0] hdr_flags;
  logic fifo_in_ready;

  // Straps come from pins, so two stages before anyone looks.
  // No reset here: the stages keep sampling during reset, so the
  // strap has settled by the time the level state captures it
  always_ff @(posedge core_clk) begin
    pins_meta <= boot_source_select_pins;
    pins_sync <= pins_meta;
  end

  // Empty count: no body to write or skip
  function automatic logic is_empty(input logic [31:0] n);
    is_empty = (n == 32'h0000_0000);
  endfunction

  // One step of a block pointer, up or down
  function automatic logic [31:0] advance(input logic [31:0] v, input logic up);
    advance = up ? v + 32'h0000_0001 : v - 32'h0000_0001;
  endfunction

  // Source bytes pass a short FIFO so the source waits on memory only once all FIFO_DEPTH entries are full
  byte_stream_if bs();

  byte_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .in_data(src_data),
    .in_valid(src_valid && src_enable),
    .in_ready(fifo_in_ready),
    .out(bs.src)
  );

  assign src_ready = fifo_in_ready && src_enable; // RL19

  header_collector u_hdr (
    .clk(core_clk),
    .rst(rst),
    .start(state == st_hdr_go),
    .busy(hdr_busy),
    .done(hdr_done),
    .bs(bs.tap),
    .addr(hdr_addr),
    .count(hdr_count),
    .flags(hdr_flags)
  );

  // Flag decode; the collector holds them until the next header
  wire flag_zero = hdr_flags[FLAG_ZERO_FILL];
  wire flag_ignore = hdr_flags[FLAG_IGNORE];
  wire flag_init = hdr_flags[FLAG_INIT];
  wire flag_last = hdr_flags[FLAG_LAST];
  wire bypass = reset_config_register[BYPASS_BIT];
  wire no_boot = (mode == MODE_NO_BOOT);

  // Body handshakes
  wire rem_zero = is_empty(remaining);
  wire wr_free = !mem_we || mem_ready;
  wire copy_rdy = (state == st_copy) && wr_free && !rem_zero;
  wire skip_rdy = (state == st_skip) && !rem_zero;
  wire copy_take = copy_rdy && bs.valid;
  wire skip_take = skip_rdy && bs.valid;
  wire fill_go = (state == st_fill) && wr_free && !rem_zero;
  wire put = copy_take || fill_go;
  wire step = put || skip_take;
  wire body_done = rem_zero && !mem_we;

  // Header, body or skip consume stream bytes; nothing else does
  assign bs.ready = hdr_busy || copy_rdy || skip_rdy; // RL19

  // Decisions that several registers follow
  wire to_jump = (next_state == st_jump);
  wire load_start = (state == st_check) && (next_state == st_hdr_go);

  always_comb begin
    next_state = state;
    unique case (state)
      st_reset_svc: next_state = st_level; // RL5
      st_level: next_state = st_check; // RL5
      st_check: begin
        if (no_boot) begin
          next_state = st_jump; // RL1
        end else if (bypass) begin
          next_state = st_jump; // RL6
        end else begin
          next_state = st_hdr_go; // RL12
        end
      end
      st_hdr_go: next_state = st_header; // RL8
      st_header: begin
        if (hdr_done) begin
          next_state = st_decide;
        end
      end
      st_decide: begin
        if (is_empty(hdr_count)) begin
          next_state = st_after; // RL11
        end else if (flag_zero) begin
          next_state = flag_ignore ? st_after : st_fill; // RL14
        end else if (flag_ignore) begin
          next_state = st_skip; // RL15
        end else begin
          next_state = st_copy; // RL10
        end
      end
      st_copy: begin
        if (body_done) begin
          next_state = st_after;
        end
      end
      st_fill: begin
        if (body_done) begin
          next_state = st_after;
        end
      end
      st_skip: begin
        if (rem_zero) begin
          next_state = st_after;
        end
      end
      st_after: begin
        next_state = (flag_init && !flag_ignore) ? st_call : st_post; // RL16
      end
      st_call: begin
        if (call_done) begin
          next_state = st_post; // RL16
        end
      end
      st_post: next_state = flag_last ? st_jump : st_hdr_go; // RL17 RL13
      st_jump: next_state = st_done;
      st_done: next_state = st_done;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= st_reset_svc;
    end else begin
      state <= next_state;
    end
  end

  // Strap caught after the synchroniser has settled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode <= MODE_NO_BOOT;
    end else if (state == st_level) begin
      mode <= pins_sync;
    end
  end

  // Per-block destination and byte count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dest <= ADDR_RESET;
      remaining <= 32'h0000_0000;
    end else if (hdr_done) begin
      dest <= hdr_addr; // RL13
      remaining <= hdr_count; // RL10
    end else if (step) begin
      dest <= advance(dest, 1'b1);
      remaining <= advance(remaining, 1'b0);
    end
  end

  // Write request holds until memory accepts it; the next byte may
  // be issued in the accepting cycle, so writes run back to back
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_we <= 1'b0;
      mem_addr <= ADDR_RESET;
      mem_wdata <= 8'h00;
    end else if (put) begin
      mem_we <= 1'b1;
      mem_addr <= dest; // RL10
      mem_wdata <= copy_take ? bs.data : 8'h00; // RL14
    end else if (mem_ready) begin
      mem_we <= 1'b0;
    end
  end

  // Init routine sits at the block's own destination
  always_ff @(posedge core_clk) begin
    if (rst) begin
      call_req <= 1'b0;
      call_addr <= ADDR_RESET;
    end else begin
      call_req <= (next_state == st_call); // RL16
      call_addr <= hdr_addr;
    end
  end

  // Source select follows the strap; disabled once execution starts
  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_enable <= 1'b0;
      src_sel <= MODE_NO_BOOT;
    end else begin
      src_sel <= mode; // RL2 RL3 RL4
      if (load_start) begin
        src_enable <= 1'b1;
      end else if (to_jump) begin
        src_enable <= 1'b0;
      end
    end
  end

  // Hand-off target: no-boot goes external, every other path to L1
  // Pins 00 win over the bypass bit, so no-boot never loads
  always_ff @(posedge core_clk) begin
    if (rst) begin
      exec_addr <= ADDR_RESET;
      exec_start <= 1'b0;
    end else begin
      exec_start <= to_jump; // RL17
      if (to_jump) begin
        exec_addr <= (state == st_check && no_boot) ? NO_BOOT_ADDR : L1_START; // RL1 RL6 RL7
      end
    end
  end

  // Privilege level never changes again after the first cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_service <= 1'b1;
      supervisor_mode <= 1'b0;
      lowest_priority_level <= 1'b0;
    end else if (state == st_reset_svc) begin
      reset_service <= 1'b0; // RL5
      supervisor_mode <= 1'b1; // RL5 RL17
      lowest_priority_level <= 1'b1; // RL5 RL17
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      boot_done <= 1'b0;
      blocks_loaded <= BLOCK_CNT_RESET;
    end else begin
      if (state == st_jump) begin
        boot_done <= 1'b1;
      end
      if (state == st_post) begin
        blocks_loaded <= blocks_loaded + 16'h0001;
      end
    end
  end

  assign loader_busy = (state != st_done);
endmodule

// [design/boot_loader_pkg.sv]
package boot_loader_pkg;
  // Boot source strap codes
  localparam logic [1:0] MODE_NO_BOOT = 2'h0;
  localparam logic [1:0] MODE_PROM = 2'h1;
  localparam logic [1:0] MODE_SPI_SLAVE = 2'h2;
  localparam logic [1:0] MODE_SPI_MEM = 2'h3;
  // Execution start addresses
  localparam logic [31:0] NO_BOOT_ADDR = 32'h2000_0000;
  localparam logic [31:0] L1_START_A = 32'hffa0_0000;
  localparam logic [31:0] L1_START_B = 32'hffa0_8000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  // Reset configuration
  localparam int RESET_CFG_W = 16;
  localparam int BYPASS_BIT = 4;
  // Block header layout, low byte first
  localparam int HDR_BYTES = 10;
  localparam int ADDR_BYTES = 4;
  localparam int COUNT_BYTES = 4;
  localparam logic [3:0] HDR_LAST_IDX = 4'h9;
  // Flag word bit positions
  localparam int FLAG_ZERO_FILL = 0;
  localparam int FLAG_IGNORE = 4;
  localparam int FLAG_INIT = 3;
  localparam int FLAG_LAST = 15;
  // Byte path
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [15:0] BLOCK_CNT_RESET = 16'h0000;
endpackage

// [design/byte_fifo.sv]
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  byte_stream_if.src out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = in_valid && !full;
  wire pop = out.valid && out.ready;

  assign in_ready = !full;
  assign out.valid = !empty;
  assign out.data = store[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// [design/byte_stream_if.sv]
`timescale 1ns/100ps
interface byte_stream_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
  modport tap(input data, input valid, input ready);
endinterface

// [design/header_collector.sv]
`timescale 1ns/100ps
module header_collector
  import boot_loader_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  output logic busy,
  output logic done,
  // Byte stream, observed only
  byte_stream_if.tap bs,
  // Decoded header
  output logic [31:0] addr,
  output logic [31:0] count,
  output logic [15:0] flags
);
  logic [3:0] idx;
  wire take = busy && bs.valid && bs.ready;
  wire in_addr = idx < 4'(ADDR_BYTES);
  wire in_count = !in_addr && (idx < 4'(ADDR_BYTES + COUNT_BYTES));
  wire last_byte = take && (idx == HDR_LAST_IDX);

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      idx <= 4'h0;
    end else begin
      done <= last_byte;
      if (start) begin
        busy <= 1'b1;
        idx <= 4'h0;
      end else if (last_byte) begin
        busy <= 1'b0;
      end else if (take) begin
        idx <= idx + 4'h1;
      end
    end
  end

  // Address, then count, then flags; each low byte first
  always_ff @(posedge clk) begin
    if (rst) begin
      addr <= ADDR_RESET;
      count <= 32'h0000_0000;
      flags <= 16'h0000;
    end else if (take && in_addr) begin
      addr[8*idx[1:0] +: 8] <= bs.data; // RL9 RL18
    end else if (take && in_count) begin
      count[8*idx[1:0] +: 8] <= bs.data; // RL9 RL18
    end else if (take) begin
      flags[8*idx[0] +: 8] <= bs.data; // RL9 RL18
    end
  end
endmodule

// [test/boot_loader_bench.sv]
`timescale 1ns/100ps
module boot_loader_bench;
  import boot_loader_pkg::*;
  logic core_clk, rst, src_valid, src_ready, src_enable, mem_we, mem_ready, call_req, call_done;
  logic exec_start, reset_service, supervisor_mode, lowest_priority_level, loader_busy, boot_done, slow;
  logic [1:0] boot_source_select_pins, src_sel;
  logic [15:0] reset_config_register, blocks_loaded;
  logic [7:0] src_data, mem_wdata;
  logic [31:0] mem_addr, call_addr, exec_addr;
  int seed = 32'h1b53d268;
  int n_fail, n_compared, nblk, i;
  logic [39:0] ew[$];
  logic [31:0] ec[$];

  boot_loader #(.l1_variant_b(1'b1)) boot_loader_inst (
    .core_clk, .rst, .boot_source_select_pins, .reset_config_register, .src_data, .src_valid, .src_ready,
    .src_enable, .src_sel, .mem_addr, .mem_wdata, .mem_we, .mem_ready, .call_addr, .call_req, .call_done,
    .exec_addr, .exec_start, .reset_service, .supervisor_mode, .lowest_priority_level, .loader_busy,
    .boot_done, .blocks_loaded
  );
  boot_source_model boot_source_model_inst (.core_clk, .rst, .slow, .src_ready, .src_data, .src_valid);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Slow memory and lazy callee keep the loader stalling
  always @(negedge core_clk) begin
    mem_ready <= $random(seed) % 4 != 0;
    call_done <= call_req && !call_done && $random(seed) % 2 == 0;
  end

  always @(posedge core_clk) begin
    if (!rst && mem_we && mem_ready)
      check({mem_addr, mem_wdata}, ew.size() > 0 ? ew.pop_front() : 40'hx);
    if (!rst && call_req && call_done)
      check({8'h00, call_addr}, {8'h00, ec.size() > 0 ? ec.pop_front() : 32'hx});
  end

  // Header low byte first, then body unless zero-filled
  task automatic blk(input logic [31:0] a, input logic [31:0] n, input logic [15:0] f);
    logic [7:0] b;
    logic [79:0] h;
    h = {f, n, a};
    for (int k = 0; k < 10; k++)
      boot_source_model_inst.push(h[8*k +: 8]);
    for (int k = 0; k < n; k++) begin
      b = f[FLAG_ZERO_FILL] ? 8'h00 : 8'($random(seed));
      if (!f[FLAG_ZERO_FILL])
        boot_source_model_inst.push(b);
      if (!f[FLAG_IGNORE])
        ew.push_back({a + 32'(k), b});
    end
    if (f[FLAG_INIT] && !f[FLAG_IGNORE])
      ec.push_back(a);
    nblk++;
  endtask

  task automatic run(input logic [1:0] p, input logic [15:0] c, input bit s, input logic [31:0] xa);
    @(negedge core_clk);
    rst = 1'b1;
    boot_source_select_pins = p;
    reset_config_register = c;
    slow = s;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    check(40'({reset_service, supervisor_mode, lowest_priority_level}), 40'h3);
    check(40'(loader_busy), 40'h1);
    i = 0;
    while (boot_done !== 1'b1 && i < 3000) begin
      @(negedge core_clk);
      i++;
    end
    if (boot_done !== 1'b1) begin
      n_fail++;
      stop_test;
    end
    check(40'(exec_addr), 40'(xa));
    check(40'(src_sel), 40'(p));
    check(40'(blocks_loaded), 40'(nblk));
    check(40'(loader_busy), 40'h0);
    check(40'(ew.size() + ec.size()), 40'h0);
    $display("test with mode %0d done", p);
    nblk = 0;
  endtask

  initial begin
    rst = 1'b1;
    boot_source_select_pins = 2'h0;
    reset_config_register = 16'h0000;
    mem_ready = 1'b0;
    call_done = 1'b0;
    slow = 1'b0;
    run(MODE_NO_BOOT, 16'(1 << BYPASS_BIT), 1'b0, NO_BOOT_ADDR);
    run(MODE_PROM, 16'(1 << BYPASS_BIT), 1'b0, L1_START_B);
    for (int m = 1; m < 4; m++) begin
      blk(32'hffa0_8000, 5, 16'h0000);
      blk(32'hff80_0010, 3, 16'(1 << FLAG_ZERO_FILL));
      blk(32'hff90_0000, 0, 16'h0000);
      blk(32'hff80_0100, 2, 16'(1 << FLAG_IGNORE));
      blk(32'hffb0_0000, 4, 16'(1 << FLAG_INIT));
      blk(32'hffa0_9000, 1, 16'(1 << FLAG_LAST));
      run(2'(m), 16'h0000, m == 2, L1_START_B);
    end
    stop_test;
  end
endmodule

// [test/boot_loader_properties.sv]
`timescale 1ns/100ps
module boot_loader_properties
  import boot_loader_pkg::*;
#(
  parameter bit l1_variant_b = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Source and memory
  input wire logic src_ready,
  input wire logic src_enable,
  input wire logic [1:0] src_sel,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_ready,
  // Call and hand-off
  input wire logic call_req,
  input wire logic call_done,
  input wire logic [31:0] exec_addr,
  input wire logic exec_start,
  input wire logic reset_service,
  input wire logic supervisor_mode,
  input wire logic lowest_priority_level,
  input wire logic boot_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  localparam logic [31:0] L1 = l1_variant_b ? L1_START_B : L1_START_A;
  sequence write_wait;
    mem_we && !mem_ready;
  endsequence
  sequence call_end;
    call_req && call_done;
  endsequence
  write_hold_a: assert property (write_wait |=> mem_we && $stable(mem_addr) && $stable(mem_wdata))
    else $error("write changed before accept");
  call_hold_a: assert property (call_req && !call_done |=> call_req)
    else $error("call dropped early");
  call_end_a: assert property (call_end |=> !call_req)
    else $error("call not ended");
  exec_pulse_a: assert property (exec_start |=> !exec_start && boot_done)
    else $error("jump pulse wrong");
  done_sticky_a: assert property (boot_done |=> boot_done && $stable(exec_addr) && !src_enable)
    else $error("jump state lost");
  ready_gate_a: assert property (src_ready |-> src_enable)
    else $error("byte taken while disabled");
  level_entry_a: assert property (!reset_service |-> supervisor_mode && lowest_priority_level)
    else $error("level not entered");
  no_boot_a: assert property (exec_start && src_sel == MODE_NO_BOOT |-> exec_addr == NO_BOOT_ADDR)
    else $error("bad no-boot target");
  l1_jump_a: assert property (exec_start && src_sel != MODE_NO_BOOT |-> exec_addr == L1)
    else $error("bad L1 target");
endmodule

bind boot_loader boot_loader_properties #(.l1_variant_b(l1_variant_b)) boot_loader_properties_inst (
  .core_clk, .rst, .src_ready, .src_enable, .src_sel, .mem_addr, .mem_wdata, .mem_we, .mem_ready,
  .call_req, .call_done, .exec_addr, .exec_start, .reset_service, .supervisor_mode,
  .lowest_priority_level, .boot_done
);

// [test/boot_source_model.sv]
`timescale 1ns/100ps
module boot_source_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pacing
  input wire logic slow,
  // Byte stream
  input wire logic src_ready,
  output logic [7:0] src_data,
  output logic src_valid
);
  logic [7:0] q[$];
  int seed = 32'h1b53d268;
  bit go;
  initial begin
    src_valid = 1'b0;
    src_data = 8'h5a;
  end
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // Idle data toggles so a stale byte never looks valid
  always @(posedge core_clk) begin
    if (rst) begin
      src_valid <= 1'b0;
    end else if (!src_valid || src_ready) begin
      if (src_valid)
        void'(q.pop_front());
      go = q.size() > 0 && !(slow && $random(seed) % 2 != 0);
      src_valid <= go;
      src_data <= go ? q[0] : ~src_data;
    end
  end
endmodule
